// >>> pkg/ctc_pkg.sv
// Constants, register map and types of the clock tree controller
// What this block does
// - Root clock picks one of three sources
// - High-speed divider factors 1,2,4,6..16 only
// - Core bus clock is root over 2^n, n<=7
// - Peripheral clock is core over 2^n, n<=3
// - Pass 10 kHz and 150 kHz clocks apart
// - Light sleep halts processor, clocks untouched
// - Deep stop stops external and high-speed sources
// - Deep stop clocks run only if source runs
// - Forced wake switches root to divided high-speed
// - Unforced wake waits for previous source stable
// - External enable takes clock from selected pin
// - External stable flag shows settled external clock
// - High-speed frequency tuned only by its trim
// - High-speed oscillator on after reset; 0 stops it unless it feeds the root
// - High-speed stable flag low until settled again
// - Divider resets to factor 6 (8 MHz)
// - Low-speed clock 32.8 kHz, tuned by trim
// - Low-speed oscillator off after reset; 1 starts
// - Low-speed stable after counted settle cycles
// - Settle select: 6, 18, 66, 258 cycles
// - Low-speed stable flag reflects settled clock
// - Reset selects divided high-speed as root
// - Stable flags clear when a source stops
package ctc_pkg;

  // ****************************************************
  // Register offsets (byte addresses)
  // ****************************************************
  localparam logic [7:0] OFS_CLK_SEL = 8'h00;
  localparam logic [7:0] OFS_OSC_EN = 8'h04;
  localparam logic [7:0] OFS_HS_CTRL = 8'h08;
  localparam logic [7:0] OFS_LS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_EXT_CTRL = 8'h10;
  localparam logic [7:0] OFS_MISC = 8'h14;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int SEL_ROOT_LSB = 0;
  localparam int SEL_CORE_LSB = 2;
  localparam int SEL_PERIPH_LSB = 5;
  localparam int EN_HS_BIT = 0;
  localparam int EN_LS_BIT = 1;
  localparam int HS_TRIM_LSB = 0;
  localparam int HS_DIV_LSB = 12;
  localparam int HS_STABLE_BIT = 16;
  localparam int LS_TRIM_LSB = 0;
  localparam int LS_WAIT_LSB = 10;
  localparam int LS_STABLE_BIT = 12;
  localparam int EXT_EN_BIT = 0;
  localparam int EXT_PIN_BIT = 1;
  localparam int EXT_STABLE_BIT = 2;
  localparam int MISC_WAKE_BIT = 0;

  // ****************************************************
  // Widths and reset values
  // ****************************************************
  localparam int HS_TRIM_W = 11;
  localparam int LS_TRIM_W = 10;
  localparam logic [1:0] ROOT_HSDIV = 2'h0;
  localparam logic [1:0] ROOT_LS = 2'h1;
  localparam logic [1:0] ROOT_EXT = 2'h2;
  localparam logic [3:0] HS_DIV_RST = 4'h3;
  localparam logic [3:0] HS_DIV_MAX = 4'h8;
  localparam logic [HS_TRIM_W-1:0] HS_TRIM_RST = 11'h400;
  localparam logic [LS_TRIM_W-1:0] LS_TRIM_RST = 10'h200;

  // ****************************************************
  // Nominal frequencies and settle counts
  // ****************************************************
  localparam int HS_NOMINAL_KHZ = 48000;
  localparam int HSDIV_RESET_KHZ = 8000;
  localparam real LS_NOMINAL_KHZ = 32.8;
  localparam logic [8:0] HS_SETTLE_CYC = 9'h010;
  localparam logic [8:0] EXT_SETTLE_CYC = 9'h010;
  localparam logic [8:0] LS_SETTLE_0 = 9'h006;
  localparam logic [8:0] LS_SETTLE_1 = 9'h012;
  localparam logic [8:0] LS_SETTLE_2 = 9'h042;
  localparam logic [8:0] LS_SETTLE_3 = 9'h102;

  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'b00,
    MODE_LIGHT = 2'b01,
    MODE_DEEP = 2'b10,
    MODE_WAKE = 2'b11
  } ctc_mode_type;

  // Divider code to half period in oscillator edges; 0 means bypass
  function automatic logic [3:0] ctc_div_half(input logic [3:0] code);
    logic [3:0] h;
    h = 4'h0;
    unique case (code)
      4'h0: h = 4'h0;
      4'h1: h = 4'h1;
      4'h2: h = 4'h2;
      4'h3: h = 4'h3;
      4'h4: h = 4'h4;
      4'h5: h = 4'h5;
      4'h6: h = 4'h6;
      4'h7: h = 4'h7;
      4'h8: h = 4'h8;
      default: h = 4'h0;
    endcase
    return h;
  endfunction

  function automatic logic [8:0] ctc_ls_settle(input logic [1:0] sel);
    logic [8:0] n;
    n = LS_SETTLE_0;
    unique case (sel)
      2'h0: n = LS_SETTLE_0;
      2'h1: n = LS_SETTLE_1;
      2'h2: n = LS_SETTLE_2;
      2'h3: n = LS_SETTLE_3;
    endcase
    return n;
  endfunction

endpackage

// >>> logic/ctc_settle_det.sv
// Counts source edges after enable and flags the source stable
`timescale 1ns/1ns
module ctc_settle_det (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Source
  input wire logic enable,
  input wire logic edge_seen,
  input wire logic [8:0] target,
  // Status
  output logic stable
);
  logic [8:0] cnt_r;
  logic stable_r;

  always_ff @(posedge ref_clk) begin
    if (rst || !enable) begin
      cnt_r <= 9'h000;
      stable_r <= 1'b0;
    end else if (edge_seen && !stable_r) begin
      cnt_r <= cnt_r + 9'h001;
      if (cnt_r + 9'h001 >= target) begin
        stable_r <= 1'b1;
      end
    end
  end

  assign stable = stable_r;
endmodule // ctc_settle_det

// >>> logic/ctc_clock_tree.sv
// Clock tree controller: source select, dividers, settle flags, low-power modes
`timescale 1ns/1ns
module ctc_clock_tree
  import ctc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Oscillator and pin clock levels
  input wire logic hs_osc_in,
  input wire logic ls_osc_in,
  input wire logic ext_pin0_in,
  input wire logic ext_pin1_in,
  input wire logic slow_10k_in,
  input wire logic filter_150k_in,
  // Power mode requests
  input wire logic sleep_enter,
  input wire logic deep_enter,
  input wire logic wake_event,
  // Oscillator control
  output logic hs_osc_run,
  output logic [ctc_pkg::HS_TRIM_W-1:0] hs_trim,
  output logic ls_osc_run,
  output logic [ctc_pkg::LS_TRIM_W-1:0] ls_trim,
  output logic ext_pin_sel,
  // Clocks out
  output logic root_clk,
  output logic core_clk,
  output logic periph_clk,
  output logic slow_10k_clk,
  output logic filter_150k_clk,
  // Processor control
  output logic cpu_halt
);
  import ctc_pkg::*;

  // ****************************************************
  // Software visible state
  // ****************************************************
  logic [1:0] root_sel_r;
  logic [2:0] core_pre_r;
  logic [1:0] periph_pre_r;
  logic hs_en_r, ls_en_r, ext_en_r, ext_pin_r, wake_force_r;
  logic [3:0] hs_div_r;
  logic [HS_TRIM_W-1:0] hs_trim_r;
  logic [LS_TRIM_W-1:0] ls_trim_r;
  logic [1:0] ls_wait_r;
  logic [31:0] rdata_r;
  ctc_mode_type mode_r;
  logic hs_stable, ls_stable, ext_stable;
  logic wake_take;
  logic deep;

  assign deep = (mode_r == MODE_DEEP);
  assign wake_take = deep && wake_event;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      root_sel_r <= ROOT_HSDIV;
      core_pre_r <= 3'h0;
      periph_pre_r <= 2'h0;
      hs_en_r <= 1'b1;
      ls_en_r <= 1'b0;
      ext_en_r <= 1'b0;
      ext_pin_r <= 1'b0;
      wake_force_r <= 1'b0;
      hs_div_r <= HS_DIV_RST;
      hs_trim_r <= HS_TRIM_RST;
      ls_trim_r <= LS_TRIM_RST;
      ls_wait_r <= 2'h0;
    end else if (wake_take && wake_force_r) begin
      root_sel_r <= ROOT_HSDIV;
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFS_CLK_SEL: begin
          // Code 3 names no source and is ignored
          if (reg_wdata[SEL_ROOT_LSB+:2] != 2'h3) begin
            root_sel_r <= reg_wdata[SEL_ROOT_LSB+:2];
          end
          core_pre_r <= reg_wdata[SEL_CORE_LSB+:3];
          periph_pre_r <= reg_wdata[SEL_PERIPH_LSB+:2];
        end
        OFS_OSC_EN: begin
          hs_en_r <= reg_wdata[EN_HS_BIT];
          ls_en_r <= reg_wdata[EN_LS_BIT];
        end
        OFS_HS_CTRL: begin
          hs_trim_r <= reg_wdata[HS_TRIM_LSB+:HS_TRIM_W];
          // Only the nine legal factors are accepted
          if (reg_wdata[HS_DIV_LSB+:4] <= HS_DIV_MAX) begin
            hs_div_r <= reg_wdata[HS_DIV_LSB+:4];
          end
        end
        OFS_LS_CTRL: begin
          ls_trim_r <= reg_wdata[LS_TRIM_LSB+:LS_TRIM_W];
          ls_wait_r <= reg_wdata[LS_WAIT_LSB+:2];
        end
        OFS_EXT_CTRL: begin
          ext_en_r <= reg_wdata[EXT_EN_BIT];
          ext_pin_r <= reg_wdata[EXT_PIN_BIT];
        end
        OFS_MISC: begin
          wake_force_r <= reg_wdata[MISC_WAKE_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************
  // Register read, data valid the cycle after the strobe
  // ****************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_r <= 32'h0000_0000;
      unique case (reg_addr)
        OFS_CLK_SEL: begin
          rdata_r[SEL_ROOT_LSB+:2] <= root_sel_r;
          rdata_r[SEL_CORE_LSB+:3] <= core_pre_r;
          rdata_r[SEL_PERIPH_LSB+:2] <= periph_pre_r;
        end
        OFS_OSC_EN: begin
          rdata_r[EN_HS_BIT] <= hs_en_r;
          rdata_r[EN_LS_BIT] <= ls_en_r;
        end
        OFS_HS_CTRL: begin
          rdata_r[HS_TRIM_LSB+:HS_TRIM_W] <= hs_trim_r;
          rdata_r[HS_DIV_LSB+:4] <= hs_div_r;
          rdata_r[HS_STABLE_BIT] <= hs_stable;
        end
        OFS_LS_CTRL: begin
          rdata_r[LS_TRIM_LSB+:LS_TRIM_W] <= ls_trim_r;
          rdata_r[LS_WAIT_LSB+:2] <= ls_wait_r;
          rdata_r[LS_STABLE_BIT] <= ls_stable;
        end
        OFS_EXT_CTRL: begin
          rdata_r[EXT_EN_BIT] <= ext_en_r;
          rdata_r[EXT_PIN_BIT] <= ext_pin_r;
          rdata_r[EXT_STABLE_BIT] <= ext_stable;
        end
        OFS_MISC: begin
          rdata_r[MISC_WAKE_BIT] <= wake_force_r;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************
  // Power mode sequencing
  // ****************************************************
  logic sel_stable;

  always_comb begin
    unique case (root_sel_r)
      ROOT_LS: sel_stable = ls_stable;
      ROOT_EXT: sel_stable = ext_stable;
      default: sel_stable = hs_stable;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_r <= MODE_ACTIVE;
    end else begin
      unique case (mode_r)
        MODE_ACTIVE: begin
          if (deep_enter) begin
            mode_r <= MODE_DEEP;
          end else if (sleep_enter) begin
            mode_r <= MODE_LIGHT;
          end
        end
        MODE_LIGHT: begin
          if (wake_event) begin
            mode_r <= MODE_ACTIVE;
          end
        end
        MODE_DEEP: begin
          if (wake_event) begin
            mode_r <= wake_force_r ? MODE_ACTIVE : MODE_WAKE;
          end
        end
        MODE_WAKE: begin
          if (sel_stable) begin
            mode_r <= MODE_ACTIVE;
          end
        end
      endcase
    end
  end

  // ****************************************************
  // Oscillator enables and stability
  // ****************************************************
  // The high-speed or low-speed source feeding the root cannot be stopped by its enable bit
  logic hs_run, ls_run, ext_run;
  logic hs_prev_r, ls_prev_r, ext_prev_r;
  logic ext_lvl;

  assign hs_run = (hs_en_r || root_sel_r == ROOT_HSDIV) && !deep;
  assign ls_run = ls_en_r || root_sel_r == ROOT_LS;
  assign ext_run = ext_en_r && !deep;
  assign ext_lvl = ext_run && (ext_pin_r ? ext_pin1_in : ext_pin0_in);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hs_prev_r <= 1'b0;
      ls_prev_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      hs_prev_r <= hs_osc_in;
      ls_prev_r <= ls_osc_in;
      ext_prev_r <= ext_lvl;
    end
  end

  ctc_settle_det u_hs_settle (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(hs_run),
    .edge_seen(hs_osc_in && !hs_prev_r),
    .target(HS_SETTLE_CYC),
    .stable(hs_stable)
  );

  ctc_settle_det u_ls_settle (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(ls_run),
    .edge_seen(ls_osc_in && !ls_prev_r),
    .target(ctc_ls_settle(ls_wait_r)),
    .stable(ls_stable)
  );

  ctc_settle_det u_ext_settle (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(ext_run),
    .edge_seen(ext_lvl && !ext_prev_r),
    .target(EXT_SETTLE_CYC),
    .stable(ext_stable)
  );

  // ****************************************************
  // High-speed divider
  // ****************************************************
  // A new factor is taken only at a low phase boundary
  logic [3:0] hs_div_act_r;
  logic [3:0] hs_cnt_r;
  logic hsdiv_r;
  logic [3:0] hs_half;

  assign hs_half = ctc_div_half(hs_div_act_r);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hs_div_act_r <= HS_DIV_RST;
      hs_cnt_r <= 4'h0;
      hsdiv_r <= 1'b0;
    end else if (!hs_run) begin
      hs_cnt_r <= 4'h0;
      hsdiv_r <= 1'b0;
      hs_div_act_r <= hs_div_r;
    end else if (hs_half == 4'h0) begin
      hsdiv_r <= hs_osc_in;
      if (!hs_osc_in) begin
        hs_div_act_r <= hs_div_r;
      end
    end else if (hs_osc_in && !hs_prev_r) begin
      if (hs_cnt_r == hs_half - 4'h1) begin
        hs_cnt_r <= 4'h0;
        hsdiv_r <= !hsdiv_r;
        if (hsdiv_r) begin
          hs_div_act_r <= hs_div_r;
        end
      end else begin
        hs_cnt_r <= hs_cnt_r + 4'h1;
      end
    end
  end

  // ****************************************************
  // Root selection
  // ****************************************************
  logic [1:0] cur_src_r;
  logic root_clk_r;
  logic cur_lvl, new_lvl;

  function automatic logic src_level(input logic [1:0] s, input logic hsd, input logic ls_r, input logic ls_l,
                                     input logic ex);
    logic v;
    v = 1'b0;
    unique case (s)
      ROOT_LS: v = ls_r && ls_l;
      ROOT_EXT: v = ex;
      default: v = hsd;
    endcase
    return v;
  endfunction

  // Stopped sources read as low, so root stops with them in deep stop
  assign cur_lvl = src_level(cur_src_r, hsdiv_r, ls_run, ls_osc_in, ext_lvl);
  assign new_lvl = src_level(root_sel_r, hsdiv_r, ls_run, ls_osc_in, ext_lvl);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur_src_r <= ROOT_HSDIV;
      root_clk_r <= 1'b0;
    end else begin
      root_clk_r <= cur_lvl;
      if (cur_src_r != root_sel_r && !cur_lvl && !new_lvl) begin
        cur_src_r <= root_sel_r;
      end
    end
  end

  // ****************************************************
  // Bus prescalers
  // ****************************************************
  logic [2:0] core_n_r;
  logic [6:0] core_cnt_r;
  logic core_clk_r;
  logic [6:0] core_lim;
  logic root_rise;

  assign root_rise = cur_lvl && !root_clk_r;
  assign core_lim = 7'(7'h01 << (core_n_r - 3'h1));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      core_n_r <= 3'h0;
      core_cnt_r <= 7'h00;
      core_clk_r <= 1'b0;
    end else begin
      if (core_n_r == 3'h0) begin
        core_clk_r <= cur_lvl;
      end else if (root_rise) begin
        if (core_cnt_r == core_lim - 7'h01) begin
          core_cnt_r <= 7'h00;
          core_clk_r <= !core_clk_r;
        end else begin
          core_cnt_r <= core_cnt_r + 7'h01;
        end
      end
      if (core_n_r != core_pre_r && core_cnt_r == 7'h00 && !core_clk_r && !cur_lvl) begin
        core_n_r <= core_pre_r;
      end
    end
  end

  logic [1:0] per_n_r;
  logic [1:0] per_cnt_r;
  logic periph_clk_r;
  logic [1:0] per_lim;
  logic core_nxt, core_rise;

  // Next core level, so the peripheral stage sees the same edge
  always_comb begin
    core_nxt = core_clk_r;
    if (core_n_r == 3'h0) begin
      core_nxt = cur_lvl;
    end else if (root_rise && core_cnt_r == core_lim - 7'h01) begin
      core_nxt = !core_clk_r;
    end
  end

  assign core_rise = core_nxt && !core_clk_r;
  assign per_lim = 2'(3'h1 << (per_n_r - 2'h1));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      per_n_r <= 2'h0;
      per_cnt_r <= 2'h0;
      periph_clk_r <= 1'b0;
    end else begin
      if (per_n_r == 2'h0) begin
        periph_clk_r <= core_nxt;
      end else if (core_rise) begin
        if (per_cnt_r == per_lim - 2'h1) begin
          per_cnt_r <= 2'h0;
          periph_clk_r <= !periph_clk_r;
        end else begin
          per_cnt_r <= per_cnt_r + 2'h1;
        end
      end
      if (per_n_r != periph_pre_r && per_cnt_r == 2'h0 && !periph_clk_r && !core_nxt) begin
        per_n_r <= periph_pre_r;
      end
    end
  end

  // ****************************************************
  // Registered outputs
  // ****************************************************
  logic hs_run_r, ls_run_r, ext_pin_out_r, slow_r, filt_r, halt_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hs_run_r <= 1'b1;
      ls_run_r <= 1'b0;
      ext_pin_out_r <= 1'b0;
      slow_r <= 1'b0;
      filt_r <= 1'b0;
      halt_r <= 1'b0;
    end else begin
      hs_run_r <= hs_run;
      ls_run_r <= ls_run;
      ext_pin_out_r <= ext_pin_r;
      // Low-speed dedicated clocks ignore every mode change
      slow_r <= slow_10k_in;
      filt_r <= filter_150k_in;
      halt_r <= (mode_r != MODE_ACTIVE) || deep_enter || sleep_enter;
    end
  end

  assign reg_rdata = rdata_r;
  assign hs_osc_run = hs_run_r;
  assign hs_trim = hs_trim_r;
  assign ls_osc_run = ls_run_r;
  assign ls_trim = ls_trim_r;
  assign ext_pin_sel = ext_pin_out_r;
  assign root_clk = root_clk_r;
  assign core_clk = core_clk_r;
  assign periph_clk = periph_clk_r;
  assign slow_10k_clk = slow_r;
  assign filter_150k_clk = filt_r;
  assign cpu_halt = halt_r;
endmodule // ctc_clock_tree

// >>> tb/ctc_clock_tree_asserts.sv
// Port-level assertions for the clock tree controller
`timescale 1ns/1ns
module ctc_clock_tree_asserts
  import ctc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // Power mode requests
  input wire logic sleep_enter,
  input wire logic deep_enter,
  // Oscillator control
  input wire logic hs_osc_run,
  input wire logic ls_osc_run,
  input wire logic [ctc_pkg::HS_TRIM_W-1:0] hs_trim,
  // Dedicated slow clocks and halt
  input wire logic slow_10k_in,
  input wire logic filter_150k_in,
  input wire logic slow_10k_clk,
  input wire logic filter_150k_clk,
  input wire logic cpu_halt
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ****************
  // Low-power modes
  // ****************
  halt_cause_a: assert property ($rose(cpu_halt) |-> $past(sleep_enter) || $past(deep_enter))
    else $error("halt rose with no entry request");
  light_keep_a: assert property (sleep_enter && !deep_enter && !cpu_halt && !reg_wr
    |=> cpu_halt && $stable(hs_osc_run) && $stable(ls_osc_run)) else $error("light sleep moved an oscillator");
  deep_stop_a: assert property (deep_enter && !cpu_halt |=> cpu_halt ##1 !hs_osc_run)
    else $error("deep stop left high-speed running");
  deep_ls_a: assert property (deep_enter && !cpu_halt && !reg_wr |=> $stable(ls_osc_run))
    else $error("deep stop moved low-speed");

  // ****************
  // Sources and registers
  // ****************
  slow_copy_a: assert property (!$past(rst) |-> slow_10k_clk == $past(slow_10k_in))
    else $error("10k clock not passed through");
  filter_copy_a: assert property (!$past(rst) |-> filter_150k_clk == $past(filter_150k_in))
    else $error("150k clock not passed through");
  hs_trim_a: assert property (reg_wr && reg_addr == OFS_HS_CTRL
    |=> hs_trim == $past(reg_wdata[HS_TRIM_W-1:0])) else $error("trim write lost");
  ls_start_a: assert property (reg_wr && reg_addr == OFS_OSC_EN && reg_wdata[EN_LS_BIT] |-> ##2 ls_osc_run)
    else $error("low-speed did not start");
endmodule // ctc_clock_tree_asserts

bind ctc_clock_tree ctc_clock_tree_asserts chk (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .sleep_enter, .deep_enter, .hs_osc_run, .ls_osc_run, .hs_trim, .slow_10k_in, .filter_150k_in,
  .slow_10k_clk, .filter_150k_clk, .cpu_halt);

// >>> tb/ctc_clock_tree_bench.sv
// Self-checking bench for the clock tree controller
`timescale 1ns/1ns
module ctc_clock_tree_bench;
  import ctc_pkg::*;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] e;
  } ctc_row_type;
  logic ref_clk, rst, reg_wr, reg_rd, sleep_enter, deep_enter, wake_event;
  logic hs_osc_in, ls_osc_in, ext_pin0_in, ext_pin1_in, slow_10k_in, filter_150k_in;
  logic hs_osc_run, ls_osc_run, ext_pin_sel, root_clk, core_clk, periph_clk;
  logic slow_10k_clk, filter_150k_clk, cpu_halt;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [HS_TRIM_W-1:0] hs_trim;
  logic [LS_TRIM_W-1:0] ls_trim;
  logic [4:0] cnt;
  logic [1:0] lsc;
  int n_mismatch = 0;
  int tests_run = 0;
  int p;
  int fct [9] = '{1, 2, 4, 6, 8, 10, 12, 14, 16};
  int lsn [4] = '{6, 18, 66, 258};
  ctc_row_type rows [10] = '{
    '{1'b0, 8'h00, 32'h0, 32'h7F, 32'h0},
    '{1'b0, 8'h04, 32'h0, 32'h3, 32'h1},
    '{1'b0, 8'h08, 32'h0, 32'hFFFF, 32'h3400},
    '{1'b0, 8'h0C, 32'h0, 32'hFFF, 32'h200},
    '{1'b1, 8'h00, 32'h28, 32'h7F, 32'h28},
    '{1'b1, 8'h00, 32'h2B, 32'h7F, 32'h28},
    '{1'b1, 8'h20, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0},
    '{1'b1, 8'h0C, 32'hC55, 32'hFFF, 32'hC55},
    '{1'b1, 8'h14, 32'h1, 32'h1, 32'h1},
    '{1'b1, 8'h10, 32'h2, 32'h3, 32'h2}};

  ctc_clock_tree uut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .hs_osc_in,
    .ls_osc_in, .ext_pin0_in, .ext_pin1_in, .slow_10k_in, .filter_150k_in, .sleep_enter, .deep_enter,
    .wake_event, .hs_osc_run, .hs_trim, .ls_osc_run, .ls_trim, .ext_pin_sel, .root_clk, .core_clk,
    .periph_clk, .slow_10k_clk, .filter_150k_clk, .cpu_halt);

  always #5 ref_clk = ~ref_clk;

  // ****************
  // Oscillators: stopped ones sit low, pins run free
  // ****************
  always @(posedge ref_clk) begin
    cnt <= cnt + 5'h01;
    lsc <= (lsc == 2'h2) ? 2'h0 : lsc + 2'h1;
    hs_osc_in <= hs_osc_run & ~hs_osc_in;
    if (lsc == 2'h2) begin
      ls_osc_in <= ls_osc_run & ~ls_osc_in;
    end
    ext_pin0_in <= cnt[1];
    ext_pin1_in <= cnt[2];
    filter_150k_in <= cnt[3];
    slow_10k_in <= cnt[4];
  end

  // ****************
  // Bus and measurement tasks
  // ****************
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    chk(nm, e, reg_rdata & m);
  endtask

  task automatic pulse(input int k);
    sleep_enter <= (k == 0);
    deep_enter <= (k == 1);
    wake_event <= (k == 2);
    @(posedge ref_clk);
    sleep_enter <= 1'b0;
    deep_enter <= 1'b0;
    wake_event <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic waith(input logic v);
    int c;
    c = 0;
    while (cpu_halt !== v && c < 80) begin
      @(negedge ref_clk);
      c++;
    end
    chk("halt", 32'(v), 32'(cpu_halt));
    @(posedge ref_clk);
  endtask

  function automatic logic pick(input int w);
    return (w == 0) ? root_clk : (w == 1) ? core_clk : periph_clk;
  endfunction

  // Period in cycles between the last two of three rises; sampled on the far edge
  task automatic per(input int w, output int n);
    int c;
    logic q;
    c = 0;
    n = 0;
    repeat (3) begin
      n = 0;
      q = pick(w);
      while (c < 2000 && !(pick(w) && !q)) begin
        q = pick(w);
        @(negedge ref_clk);
        c++;
        n++;
      end
    end
    @(posedge ref_clk);
  endtask

  task automatic still(input string nm);
    int n;
    logic q;
    n = 0;
    repeat (4) @(negedge ref_clk);
    q = root_clk;
    repeat (40) begin
      @(negedge ref_clk);
      if (root_clk !== q) n++;
      q = root_clk;
    end
    chk(nm, 32'h0, 32'(n));
    @(posedge ref_clk);
  endtask

  initial begin
    repeat (30000) @(posedge ref_clk);
    $display("watchdog expired");
    n_mismatch++;
    conclude();
  end

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    {reg_wr, reg_rd, sleep_enter, deep_enter, wake_event} = 5'h00;
    {hs_osc_in, ls_osc_in, ext_pin0_in, ext_pin1_in, slow_10k_in, filter_150k_in} = 6'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    cnt = 5'h00;
    lsc = 2'h0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rdc("row", rows[i].a, rows[i].m, rows[i].e);
    end
    $display("register rows done");
    // Divider is only reprogrammed while its oscillator is stopped
    wr(8'h04, 32'h3);
    repeat (60) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      wr(8'h00, 32'h29);
      wr(8'h04, 32'h2);
      rdc("hs stable off", 8'h08, 32'h10000, 32'h0);
      chk("hs run off", 32'h0, 32'(hs_osc_run));
      wr(8'h08, (32'(i) << 12) | 32'h400);
      if (i == 9) rdc("div refused", 8'h08, 32'hF000, 32'h8000);
      if (i == 9) wr(8'h08, 32'h3400);
      wr(8'h04, 32'h3);
      wr(8'h00, 32'h28);
      repeat (40) @(posedge ref_clk);
      rdc("hs stable on", 8'h08, 32'h10000, 32'h10000);
      per(0, p);
      chk("root", 32'(2 * fct[(i == 9) ? 3 : i]), 32'(p));
    end
    per(1, p);
    chk("core", 32'd48, 32'(p));
    per(2, p);
    chk("periph", 32'd96, 32'(p));
    for (int k = 0; k < 4; k++) begin
      wr(8'h04, 32'h1);
      rdc("ls stable off", 8'h0C, 32'h1000, 32'h0);
      wr(8'h0C, (32'(k) << 10) | 32'h200);
      wr(8'h04, 32'h3);
      repeat (6 * lsn[k] - 14) @(posedge ref_clk);
      rdc("ls early", 8'h0C, 32'h1000, 32'h0);
      repeat (20) @(posedge ref_clk);
      rdc("ls stable", 8'h0C, 32'h1000, 32'h1000);
    end
    $display("dividers and settle counts done");
    wr(8'h10, 32'h3);
    rdc("ext early", 8'h10, 32'h4, 32'h0);
    chk("pin sel", 32'h1, 32'(ext_pin_sel));
    repeat (160) @(posedge ref_clk);
    rdc("ext stable", 8'h10, 32'h4, 32'h4);
    wr(8'h00, 32'h2A);
    per(0, p);
    chk("ext root", 32'd8, 32'(p));
    wr(8'h14, 32'h1);
    pulse(1);
    waith(1'b1);
    chk("deep hs", 32'h0, 32'(hs_osc_run));
    chk("deep ls", 32'h1, 32'(ls_osc_run));
    rdc("ext off", 8'h10, 32'h4, 32'h0);
    still("ext root stopped");
    pulse(2);
    waith(1'b0);
    rdc("forced root", 8'h00, 32'h3, 32'h0);
    wr(8'h14, 32'h0);
    pulse(1);
    waith(1'b1);
    still("hs root stopped");
    pulse(2);
    repeat (10) @(posedge ref_clk);
    chk("halt held", 32'h1, 32'(cpu_halt));
    waith(1'b0);
    wr(8'h00, 32'h29);
    pulse(1);
    waith(1'b1);
    per(2, p);
    chk("deep periph", 32'd48, 32'(p));
    pulse(2);
    waith(1'b0);
    pulse(0);
    waith(1'b1);
    chk("sleep hs", 32'h1, 32'(hs_osc_run));
    per(0, p);
    chk("sleep root", 32'd6, 32'(p));
    pulse(2);
    waith(1'b0);
    $display("low power modes done");
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk("rst hs run", 32'h1, 32'(hs_osc_run));
    chk("rst ls run", 32'h0, 32'(ls_osc_run));
    chk("rst hs trim", 32'h400, 32'(hs_trim));
    chk("rst ls trim", 32'h200, 32'(ls_trim));
    chk("rst halt", 32'h0, 32'(cpu_halt));
    @(posedge ref_clk);
    rdc("rst root", 8'h00, 32'h7F, 32'h0);
    $display("second reset done");
    conclude();
  end
endmodule // ctc_clock_tree_bench
